// File: verilog/boundary_scan_regs.svh
// constants of the boundary-scan test access port
// Summary of operation
// - three scan cells per pin, each with serial in and out and parallel in; only output and enable cells have parallel out
// - all cells form one chain from data input to data output
// - cell parallel side ties to core and pin input, output, enable
// - mode select sampled on each rising test clock edge
// - instruction and data bits taken from data input on rising edge
// - data output changes on falling test clock edge
// - data output floats unless a shift is in progress
// - instruction register is three bits, decodes five instructions
// - code 000 drives pins from chain and captures pin states
// - code 001 captures pin states, normal operation continues
// - code 101 floats every user pin
// - code 110 drives pins from chain, scan path is bypass bit
// - code 111 puts one bypass bit between data input and output
// - no reset pin; five clocks of mode select high or power-on reset
// - mode select pulled up so controller rests in reset when undriven
// - test pins not reserved: pins are user I/O, test logic idle
`ifndef BOUNDARY_SCAN_REGS_SVH
`define BOUNDARY_SCAN_REGS_SVH

`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_SAMPLE 3'h1
`define IR_HIGHZ 3'h5
`define IR_CLAMP 3'h6
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define CELLS_PER_IO 3
`define CELL_IN 0
`define CELL_OUT 1
`define CELL_OE 2
`define RESET_TMS_CLOCKS 5
`define SYS_CLK_MHZ 250
`define TCK_MAX_MHZ 20
`define SYS_CYCLES_PER_TCK (`SYS_CLK_MHZ / `TCK_MAX_MHZ)

`endif

// File: verilog/boundary_scan_pkg.sv
// types of the test access port controller: its states and the instruction
package boundary_scan_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_e;

    typedef logic [2:0] instr_t;

endpackage : boundary_scan_pkg

// File: verilog/bsr_if.sv
// link between the port controller and the boundary cell chain
`timescale 1ns/1ns
interface bsr_if #(parameter int NUM_IO = 8);
    logic capture;
    logic shift;
    logic update;
    logic si;
    logic so;
    logic [NUM_IO-1:0] upd_out;
    logic [NUM_IO-1:0] upd_oe;

    modport tap (output capture, output shift, output update, output si,
        input so, input upd_out, input upd_oe);
    modport chain (input capture, input shift, input update, input si,
        output so, output upd_out, output upd_oe);
endinterface : bsr_if

// File: verilog/boundary_chain.sv
// boundary-scan register: three cells per pin with update stage
`timescale 1ns/1ns
`include "boundary_scan_regs.svh"
module boundary_chain #(
    parameter int NUM_IO = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // asynchronous reset
    input wire logic [NUM_IO-1:0] pin_level, // synchronised pin input
    input wire logic [NUM_IO-1:0] core_out, // core output value
    input wire logic [NUM_IO-1:0] core_oe, // core output enable
    bsr_if.chain bif // control from the port controller
);
    localparam int LEN = `CELLS_PER_IO * NUM_IO;

    logic [LEN-1:0] shift_q;
    logic [LEN-1:0] shift_d;
    logic [LEN-1:0] upd_q;
    logic [LEN-1:0] capt_w;

    // ========================================
    // capture and shift paths
    // ========================================
    genvar i;
    generate
        for (i = 0; i < NUM_IO; i++) begin : g_cell
            assign capt_w[`CELLS_PER_IO*i+`CELL_IN] = pin_level[i];
            assign capt_w[`CELLS_PER_IO*i+`CELL_OUT] = core_out[i];
            assign capt_w[`CELLS_PER_IO*i+`CELL_OE] = core_oe[i];
            assign bif.upd_out[i] = upd_q[`CELLS_PER_IO*i+`CELL_OUT];
            assign bif.upd_oe[i] = upd_q[`CELLS_PER_IO*i+`CELL_OE];
        end
    endgenerate

    // chain runs from the data input at the top bit to the output at bit 0
    assign shift_d = {bif.si, shift_q[LEN-1:1]};
    assign bif.so = shift_q[0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
        end else if (bif.capture) begin
            shift_q <= capt_w;
        end else if (bif.shift) begin
            shift_q <= shift_d;
        end
    end

    // update stage keeps pins steady while new data shifts through
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upd_q <= '0;
        end else if (bif.update) begin
            upd_q <= shift_q;
        end
    end

endmodule : boundary_chain

// File: verilog/boundary_scan_tap.sv
// test access port controller with instruction decode and pin muxing
`timescale 1ns/1ns
`include "boundary_scan_regs.svh"
module boundary_scan_tap
    import boundary_scan_pkg::*;
#(
    parameter int NUM_IO = 8
) (
    input wire logic clk_sys, // system clock, 250 MHz
    input wire logic rst, // asynchronous power-on reset
    input wire logic test_pins_reserved, // configuration: test pins in use
    input wire logic tck, // test clock pin
    input wire logic tms, // mode select pin, pulled up at the pad
    input wire logic tdi, // test data input pin
    output logic tdo_o, // test data output value
    output logic tdo_oe, // test data output enable, high drives
    input wire logic [NUM_IO-1:0] core_out, // core output values
    input wire logic [NUM_IO-1:0] core_oe, // core output enables
    output logic [NUM_IO-1:0] core_in, // pin levels toward the core
    input wire logic [NUM_IO-1:0] pad_in, // pin levels from the pads
    output logic [NUM_IO-1:0] pad_out, // values driven onto the pads
    output logic [NUM_IO-1:0] pad_oe // pad output enables, high drives
);

    // ========================================
    // pin synchronisers
    // ========================================
    logic tck_meta_q;
    logic tck_s_q;
    logic tck_prev_q;
    logic tms_meta_q;
    logic tms_s_q;
    logic tdi_meta_q;
    logic tdi_s_q;
    logic rsv_meta_q;
    logic rsv_s_q;
    logic [NUM_IO-1:0] pad_meta_q;
    logic [NUM_IO-1:0] pad_s_q;

    // the test clock is slow enough (see the constants) to be oversampled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tck_meta_q <= 1'b0;
            tck_s_q <= 1'b0;
            tck_prev_q <= 1'b0;
            tms_meta_q <= 1'b1;
            tms_s_q <= 1'b1;
            tdi_meta_q <= 1'b0;
            tdi_s_q <= 1'b0;
            rsv_meta_q <= 1'b0;
            rsv_s_q <= 1'b0;
        end else begin
            tck_meta_q <= tck;
            tck_s_q <= tck_meta_q;
            tck_prev_q <= tck_s_q;
            tms_meta_q <= tms;
            tms_s_q <= tms_meta_q;
            tdi_meta_q <= tdi;
            tdi_s_q <= tdi_meta_q;
            rsv_meta_q <= test_pins_reserved;
            rsv_s_q <= rsv_meta_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pad_meta_q <= '0;
            pad_s_q <= '0;
        end else begin
            pad_meta_q <= pad_in;
            pad_s_q <= pad_meta_q;
        end
    end

    // ========================================
    // test clock edges
    // ========================================
    logic tck_rise;
    logic tck_fall;
    logic active;

    assign tck_rise = tck_s_q & ~tck_prev_q;
    assign tck_fall = ~tck_s_q & tck_prev_q;
    assign active = rsv_s_q;

    // ========================================
    // controller state machine
    // ========================================
    function automatic tap_state_e tap_next(input tap_state_e s,
                                            input logic m);
        tap_state_e n;
        n = TEST_LOGIC_RESET;
        case (s)
            TEST_LOGIC_RESET: n = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: n = m ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: n = m ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: n = m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: n = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: n = m ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: n = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: n = m ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: n = m ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: n = m ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: n = m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: n = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: n = m ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: n = m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: n = m ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: n = m ? SELECT_DR : RUN_TEST_IDLE;
            default: n = TEST_LOGIC_RESET;
        endcase
        return n;
    endfunction : tap_next

    tap_state_e state_q;
    tap_state_e state_d;

    // mode select high walks any state to reset within five test clocks
    assign state_d = tap_next(state_q, tms_s_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= TEST_LOGIC_RESET;
        end else if (!active) begin
            state_q <= TEST_LOGIC_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // ========================================
    // instruction register and decode
    // ========================================
    instr_t ir_shift_q;
    instr_t instruction_reg_q;
    logic sel_extest;
    logic sel_sample;
    logic sel_highz;
    logic sel_clamp;
    logic bsr_sel;
    logic drive_test;
    logic in_reset;

    assign in_reset = (state_q == TEST_LOGIC_RESET);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ir_shift_q <= `IR_CAPTURE;
        end else if (tck_rise && state_q == CAPTURE_IR) begin
            ir_shift_q <= `IR_CAPTURE;
        end else if (tck_rise && state_q == SHIFT_IR) begin
            ir_shift_q <= {tdi_s_q, ir_shift_q[`IR_WIDTH-1:1]};
        end
    end

    // new instruction takes effect on the falling edge in update
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            instruction_reg_q <= `IR_BYPASS;
        end else if (in_reset) begin
            instruction_reg_q <= `IR_BYPASS;
        end else if (tck_fall && state_q == UPDATE_IR) begin
            instruction_reg_q <= ir_shift_q;
        end
    end

    assign sel_extest = (instruction_reg_q == `IR_EXTEST);
    assign sel_sample = (instruction_reg_q == `IR_SAMPLE);
    assign sel_highz = (instruction_reg_q == `IR_HIGHZ);
    assign sel_clamp = (instruction_reg_q == `IR_CLAMP);
    // every other code, listed bypass or not, scans through the bypass bit
    assign bsr_sel = sel_extest | sel_sample;
    assign drive_test = sel_extest | sel_clamp;

    // ========================================
    // bypass bit and chain control
    // ========================================
    logic bypass_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && state_q == CAPTURE_DR) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && state_q == SHIFT_DR) begin
            bypass_q <= tdi_s_q;
        end
    end

    bsr_if #(.NUM_IO(NUM_IO)) bif ();

    assign bif.capture = tck_rise & bsr_sel & (state_q == CAPTURE_DR);
    assign bif.shift = tck_rise & bsr_sel & (state_q == SHIFT_DR);
    assign bif.update = tck_fall & bsr_sel & (state_q == UPDATE_DR);
    assign bif.si = tdi_s_q;

    boundary_chain #(.NUM_IO(NUM_IO)) u_chain (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_level(pad_s_q),
        .core_out(core_out),
        .core_oe(core_oe),
        .bif(bif)
    );

    // ========================================
    // serial data output
    // ========================================
    logic shifting;
    logic serial_bit;
    logic tdo_q;
    logic tdo_oe_q;

    assign shifting = (state_q == SHIFT_DR) || (state_q == SHIFT_IR);
    assign serial_bit = (state_q == SHIFT_IR) ? ir_shift_q[0] :
                        bsr_sel ? bif.so : bypass_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (!active) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= serial_bit;
            tdo_oe_q <= shifting;
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ========================================
    // pin muxing
    // ========================================
    logic [NUM_IO-1:0] pad_out_d;
    logic [NUM_IO-1:0] pad_oe_d;
    logic [NUM_IO-1:0] pad_out_q;
    logic [NUM_IO-1:0] pad_oe_q;
    logic [NUM_IO-1:0] core_in_q;

    // sample/preload leaves the core in charge of the pins
    assign pad_out_d = drive_test ? bif.upd_out : core_out;
    assign pad_oe_d = sel_highz ? '0 :
                      drive_test ? bif.upd_oe : core_oe;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pad_out_q <= '0;
            pad_oe_q <= '0;
            core_in_q <= '0;
        end else begin
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
            core_in_q <= pad_s_q;
        end
    end

    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;
    assign core_in = core_in_q;

endmodule : boundary_scan_tap

// File: tb/tap_pin_checker_assertions.sv
// pin-level assertions for the test access port
`timescale 1ns/1ns
module tap_pin_checker #(
    parameter int NUM_IO = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset
    input wire logic test_pins_reserved, // test logic on
    input wire logic tck, // test clock pin
    input wire logic tms, // mode select pin
    input wire logic tdo_o, // data out
    input wire logic tdo_oe, // data out enable
    input wire logic [NUM_IO-1:0] core_out, // core values
    input wire logic [NUM_IO-1:0] core_oe, // core enables
    input wire logic [NUM_IO-1:0] core_in, // toward core
    input wire logic [NUM_IO-1:0] pad_in, // from pads
    input wire logic [NUM_IO-1:0] pad_out, // onto pads
    input wire logic [NUM_IO-1:0] pad_oe // pad enables
);
    // ==========
    // edge history of the test clock pin
    logic tck_q;
    logic [3:0] fall_cnt_q;
    logic [3:0] edge_cnt_q;
    logic [3:0] age_q;
    logic [2:0] ones_q;
    logic quiet_q;
    wire tck_fall = tck_q & ~tck;
    wire tck_edge = tck_q ^ tck;
    wire tck_rise = ~tck_q & tck;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tck_q <= 1'b0;
            fall_cnt_q <= 4'hf;
            edge_cnt_q <= 4'hf;
            age_q <= 4'h0;
            ones_q <= 3'h0;
            quiet_q <= 1'b1;
        end else begin
            tck_q <= tck;
            fall_cnt_q <= tck_fall ? 4'h0 : fall_cnt_q + {3'h0, &fall_cnt_q == 1'b0};
            edge_cnt_q <= tck_edge ? 4'h0 : edge_cnt_q + {3'h0, &edge_cnt_q == 1'b0};
            age_q <= age_q + {3'h0, &age_q == 1'b0};
            if (tck_rise) begin
                ones_q <= tms ? ones_q + {2'h0, &ones_q == 1'b0} : 3'h0;
                quiet_q <= 1'b0;
            end
        end
    end
    // ==========
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence pad_steady;
        $stable(pad_in) [*4];
    endsequence
    chk_tdo_on_fall:
    assert property ($changed(tdo_o) && test_pins_reserved
        && $past(test_pins_reserved, 3) |-> fall_cnt_q inside {[1:6]})
        else $error("data out moved without a test clock fall");
    chk_oe_on_fall:
    assert property ($changed(tdo_oe) && test_pins_reserved
        && $past(test_pins_reserved, 3) |-> fall_cnt_q inside {[1:6]})
        else $error("data out enable moved without a test clock fall");
    chk_idle_unreserved:
    assert property (!test_pins_reserved [*4] |-> !tdo_oe)
        else $error("data out driven while test pins not reserved");
    chk_reset_quiet:
    assert property ($fell(rst) |-> !tdo_oe && !tdo_o)
        else $error("data out active after reset");
    chk_core_follows:
    assert property (pad_steady ##0 age_q > 4'h6 |-> core_in == pad_in)
        else $error("core input does not follow pad");
    chk_pads_at_start:
    assert property (quiet_q && age_q != 4'h0 |-> pad_out == $past(core_out)
        && pad_oe == $past(core_oe))
        else $error("pads not driven by core after reset");
    chk_pad_cause:
    assert property (($changed(pad_out) || $changed(pad_oe)) && age_q > 4'h3
        |-> edge_cnt_q inside {[1:7]} || $past(core_out) != $past(core_out, 2)
        || $past(core_oe) != $past(core_oe, 2))
        else $error("pads changed with no cause");
    chk_tms_reset:
    assert property (ones_q > 3'h4 |-> !tdo_oe)
        else $error("data out driven after mode select reset");
endmodule : tap_pin_checker

bind boundary_scan_tap tap_pin_checker #(.NUM_IO(NUM_IO)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .test_pins_reserved(test_pins_reserved),
    .tck(tck), .tms(tms), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// File: tb/tap_controller_model.sv
// board test controller driving the serial test port
`timescale 1ns/1ns
module tap_controller_model (
    input wire logic clk_sys, // paces the test clock
    output logic tck, // test clock, still between frames
    output logic tms, // mode select
    output logic tdi, // data toward the port
    input wire logic tdo_o, // data from the port
    input wire logic tdo_oe // high while the port drives
);
    // ==========
    // one test clock cycle and whole scans
    localparam int HALF = 8; // 64 ns period, below 20 MHz
    logic tdo_seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        tdo_seen = 1'b0;
    end
    task automatic tick(input logic m, input logic d);
        tms = m;
        tdi = d;
        repeat (HALF) @(posedge clk_sys);
        #1;
        // a floating line reads as noise, never as the last bit
        tdo_seen = tdo_oe ? tdo_o : ~tdo_seen;
        tck = 1'b1;
        repeat (HALF) @(posedge clk_sys);
        #1;
        tck = 1'b0;
    endtask : tick
    task automatic reset_tap();
        repeat (5) tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
    endtask : reset_tap
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        dout = '0;
        tick(1'b1, ~tdi);
        if (ir) tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
        tick(1'b0, ~tdi);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = tdo_seen;
        end
        tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
    endtask : scan
endmodule : tap_controller_model

// File: tb/tb_boundary_scan_tap.sv
// self-checking bench for the test access port
`timescale 1ns/1ns
`include "boundary_scan_regs.svh"
module tb_boundary_scan_tap;
    localparam int NUM_IO = 8;
    localparam int CHAIN = `CELLS_PER_IO * NUM_IO;
    localparam logic [31:0] PRE = 32'h0a5c3e71;
    localparam logic [31:0] EXT = 32'h01c3a95e;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic test_pins_reserved = 1'b1;
    logic tck, tms, tdi, tdo_o, tdo_oe;
    logic [NUM_IO-1:0] core_out = 8'h3c;
    logic [NUM_IO-1:0] core_oe = 8'hf0;
    logic [NUM_IO-1:0] pad_in = 8'ha5;
    logic [NUM_IO-1:0] core_in, pad_out, pad_oe;
    logic [31:0] d;
    int errors = 0;
    int cmp_count = 0;

    always #2 clk_sys = ~clk_sys;

    boundary_scan_tap #(.NUM_IO(NUM_IO)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .test_pins_reserved(test_pins_reserved),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    tap_controller_model i_ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

    // ==========
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [NUM_IO-1:0] picked(input logic [31:0] v);
        for (int i = 0; i < NUM_IO; i++) picked[i] = v[3*i];
    endfunction : picked
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done
    task automatic pads_core();
        check({pad_oe, pad_out}, {core_oe, core_out});
    endtask : pads_core
    // update cells hold the scanned word moved down by one place
    task automatic pads_from(input logic [31:0] v);
        check({pad_oe, pad_out}, {picked(v >> 3), picked(v >> 2)});
    endtask : pads_from
    task automatic load_ir(input logic [2:0] code);
        i_ctl.scan(1'b1, 3, {29'h0, code}, d);
        check(d[2:0], `IR_CAPTURE);
    endtask : load_ir
    task automatic bypass_ok();
        i_ctl.scan(1'b0, 2, 32'h1, d);
        check(d[1:0], 2'h2);
    endtask : bypass_ok

    // ==========
    // scenarios
    task automatic t_reset_bypass();
        pads_core();
        // a scan opens from idle, so leave the reset state first
        i_ctl.reset_tap();
        i_ctl.scan(1'b0, 9, 32'h1a5, d);
        check(d[8:0], 9'h14a);
        done("reset_bypass");
    endtask : t_reset_bypass
    task automatic t_sample();
        load_ir(`IR_SAMPLE);
        i_ctl.scan(1'b0, CHAIN + 1, PRE, d);
        check(picked(d), pad_in);
        check(d[CHAIN], PRE[0]);
        core_out = 8'h5a;
        step(3);
        pads_core();
        done("sample");
    endtask : t_sample
    task automatic t_extest();
        load_ir(`IR_EXTEST);
        pads_from(PRE);
        pad_in = 8'h3b;
        step(8);
        i_ctl.scan(1'b0, CHAIN + 1, EXT, d);
        check(picked(d), pad_in);
        pads_from(EXT);
        done("extest");
    endtask : t_extest
    task automatic t_clamp_highz();
        load_ir(`IR_CLAMP);
        bypass_ok();
        pads_from(EXT);
        load_ir(`IR_HIGHZ);
        check(pad_oe, 8'h00);
        done("clamp_highz");
    endtask : t_clamp_highz
    task automatic t_unlisted();
        for (int c = 2; c < 5; c++) begin
            load_ir(c[2:0]);
            bypass_ok();
            pads_core();
        end
        done("unlisted");
    endtask : t_unlisted
    task automatic t_tms_reset();
        load_ir(`IR_EXTEST);
        i_ctl.tick(1'b1, 1'b0);
        i_ctl.tick(1'b0, 1'b1);
        i_ctl.tick(1'b0, 1'b0);
        i_ctl.tick(1'b0, 1'b1);
        i_ctl.reset_tap();
        pads_core();
        bypass_ok();
        done("tms_reset");
    endtask : t_tms_reset
    task automatic t_unreserved();
        test_pins_reserved = 1'b0;
        i_ctl.scan(1'b1, 3, {29'h0, `IR_EXTEST}, d);
        test_pins_reserved = 1'b1;
        step(2);
        pads_core();
        i_ctl.reset_tap();
        bypass_ok();
        done("unreserved");
    endtask : t_unreserved

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        step(3);
        rst = 1'b0;
        step(4);
        t_reset_bypass();
        t_sample();
        t_extest();
        t_clamp_highz();
        t_unlisted();
        t_tms_reset();
        t_unreserved();
        final_report();
    end
    // scans take well under 100 us; a hang is cut at 200 us
    initial begin
        #200000;
        errors++;
        final_report();
    end
endmodule : tb_boundary_scan_tap
